//--- design/rscfg_pkg.sv
// Package: register map, field layout, resets and scaling for the config bank
`default_nettype none
package rscfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_IF_CTRL   = 16'hdf07;
  localparam logic [15:0] IDX_OFF_CTRL  = 16'hdf08;
  localparam logic [15:0] IDX_BASE_HI   = 16'hdf09;
  localparam logic [15:0] IDX_BASE_MID  = 16'hdf0a;
  localparam logic [15:0] IDX_BASE_LO   = 16'hdf0b;
  localparam logic [15:0] IDX_BW_RATE   = 16'hdf0c;
  localparam logic [15:0] IDX_RATE_MANT = 16'hdf0d;
  // Reset values of the stored fields
  localparam logic [4:0]  RST_IF_WORD   = 5'h0f;
  localparam logic        RST_IF_RSVD   = 1'b0;
  localparam logic [7:0]  RST_OFFSET    = 8'h00;
  localparam logic [1:0]  BASE_TOP_BITS = 2'h1;
  localparam logic [5:0]  RST_BASE_HI   = 6'h1e;
  localparam logic [7:0]  RST_BASE_MID  = 8'hc4;
  localparam logic [7:0]  RST_BASE_LO   = 8'hec;
  localparam logic [1:0]  RST_BW_EXP    = 2'h2;
  localparam logic [1:0]  RST_BW_MANT   = 2'h0;
  localparam logic [3:0]  RST_RATE_EXP  = 4'hc;
  localparam logic [7:0]  RST_RATE_MANT = 8'h22;
  // Field positions
  localparam int IF_RSVD_BIT = 5;
  localparam int BW_EXP_LSB  = 6;
  localparam int BW_MANT_LSB = 4;
  // Scaling into base-word steps (fref/2^16)
  localparam int BASE_FRAC   = 16;
  localparam int OFF_FRAC    = 14;
  localparam int IF_FRAC     = 10;
  localparam int OFF_SHIFT   = BASE_FRAC - OFF_FRAC;
  localparam int IF_SHIFT    = BASE_FRAC - IF_FRAC;
  // Bandwidth and rate constants
  localparam logic [8:0]  BW_MANT_BIAS = 9'h004;
  localparam int          BW_DIV_SHIFT = 3;
  localparam logic [23:0] RATE_HIDDEN  = 24'h00_0100;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- design/rscfg_synth_word.sv
// Synthesizer frequency word: base plus channel, offset, minus IF in receive
`default_nettype none
module rscfg_synth_word (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic [23:0] i_base_word,
  input  wire logic [7:0]  i_offset_word,
  input  wire logic [4:0]  i_if_word,
  input  wire logic [7:0]  i_channel_index,
  input  wire logic [15:0] i_channel_index_spacing,
  input  wire logic        i_rx_active,
  output logic      [23:0] o_synth_word
);
  // Terms in base-word steps, 26 bits signed to hold carries
  logic signed [25:0] term_channel_index;
  logic signed [25:0] term_off;
  logic signed [25:0] term_if;
  logic signed [25:0] next_sum;

  // Combine terms
  always_comb begin
    term_channel_index = signed'(26'(i_channel_index * i_channel_index_spacing));
    term_off  = 26'(signed'(i_offset_word)) <<< rscfg_pkg::OFF_SHIFT;
    term_if   = signed'(26'(i_if_word) << rscfg_pkg::IF_SHIFT);
    next_sum  = signed'(26'(i_base_word)) + term_channel_index + term_off;
    // IF is only pulled off the carrier while receiving
    if (i_rx_active) begin
      next_sum = next_sum - term_if;
    end
  end

  // Register the word; wraps modulo 2^24 like the synthesizer accumulator
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_synth_word <= 24'h00_0000;
    end else begin
      o_synth_word <= next_sum[23:0];
    end
  end

  // Output lags its inputs by one edge, so compare against past inputs
  a_rx_if_pull: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_rx_active |=> (o_synth_word == 24'($past(i_base_word)
     + $past(i_channel_index) * $past(i_channel_index_spacing)
     + ({{16{$past(i_offset_word[7])}}, $past(i_offset_word)} << 2)
     - ({19'h0_0000, $past(i_if_word)} << 6))))
    else $error("Receive synth word wrong");
endmodule // rscfg_synth_word
`default_nettype wire

//--- design/rscfg_rate_calc.sv
// Channel filter decimation ratio and symbol-rate numerator
`default_nettype none
module rscfg_rate_calc (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic [1:0]  i_bw_exp,
  input  wire logic [1:0]  i_bw_mant,
  input  wire logic [3:0]  i_rate_exp,
  input  wire logic [7:0]  i_rate_mant,
  output logic      [8:0]  o_decim_ratio,
  output logic      [23:0] o_rate_word
);
  // Decimation = 8*(4+M)*2^E, bandwidth = fref / decimation
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_decim_ratio <= 9'h000;
    end else begin
      o_decim_ratio <= (rscfg_pkg::BW_MANT_BIAS + 9'(i_bw_mant))
        << (rscfg_pkg::BW_DIV_SHIFT + int'(i_bw_exp));
    end
  end

  // Rate = word * fref / 2^28, hidden ninth mantissa bit
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rate_word <= 24'h00_0000;
    end else begin
      o_rate_word <= (rscfg_pkg::RATE_HIDDEN + 24'(i_rate_mant))
        << i_rate_exp;
    end
  end

  a_decim_ratio: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $stable(i_bw_exp) && $stable(i_bw_mant) |=>
    o_decim_ratio == 9'(8 * (4 + $past(i_bw_mant))
      * (1 << $past(i_bw_exp))))
    else $error("Decimation ratio wrong");
  a_rate_word: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $stable(i_rate_exp) && $stable(i_rate_mant) |=>
    o_rate_word == 24'((256 + $past(i_rate_mant))
      * (1 << $past(i_rate_exp))))
    else $error("Rate word wrong");
endmodule // rscfg_rate_calc
`default_nettype wire

//--- design/rscfg_regs.sv
// Radio synthesizer and modem rate configuration bank on AXI4-Lite
// Contract
// - IF word subtracted in receive, drives mixer
// - IF equals field times fref over 2^10
// - Signed offset added, step fref over 2^14
// - 24-bit base word, top two bits 01
// - Bandwidth from 2-bit exponent and mantissa
// - Rate float: hidden one, 4-bit exponent
// - Rate exponent low nibble, resets 1100
// - Rate mantissa byte resets to 0x22
// - Channel index times spacing added to base
`default_nettype none
module rscfg_regs #(
  parameter int ADDR_W = 18 // Byte address width
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic      [1:0]        o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic      [31:0]       o_rdata,
  output logic      [1:0]        o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire logic [7:0]        i_channel_index,
  input  wire logic [15:0]       i_channel_index_spacing,
  input  wire logic              i_rx_active,
  output logic      [4:0]        o_if_base_word_a_word,
  output logic      [7:0]        o_synth_offset_word,
  output logic      [23:0]       o_base_word_a,
  output logic      [1:0]        o_bandwidth_exponent,
  output logic      [1:0]        o_bandwidth_mantissa,
  output logic      [3:0]        o_symbol_rate_exponent,
  output logic      [7:0]        o_symbol_rate_mantissa,
  output logic      [23:0]       o_synth_word,
  output logic      [8:0]        o_decim_ratio,
  output logic      [23:0]       o_rate_word
);
  // Write channel holding state
  logic [15:0] aw_idx;   // Captured word index
  logic        aw_held;  // Address taken, awaiting commit
  logic [7:0]  w_byte;   // Captured low data byte
  logic        w_lane;   // Low byte lane enabled
  logic        w_held;   // Data taken, awaiting commit
  logic        commit;   // Both halves present, response free
  logic        if_rsvd;  // Reserved bit of IF register
  logic [7:0]  rd_byte;  // Read decode result
  logic        rd_hit;   // Read index is mapped
  logic        wr_hit;   // Write index is mapped

  assign commit = aw_held && w_held && !o_bvalid;

  // Map a word index to its read value
  function automatic logic [8:0] read_reg(input logic [15:0] idx,
      input logic [4:0] ifw, input logic rsv, input logic [7:0] off,
      input logic [23:0] base, input logic [7:0] bwr, input logic [7:0] rm);
    logic [8:0] res;
    res = 9'h000;
    unique case (idx)
      rscfg_pkg::IDX_IF_CTRL:   res = {1'b1, 2'b00, rsv, ifw};
      rscfg_pkg::IDX_OFF_CTRL:  res = {1'b1, off};
      rscfg_pkg::IDX_BASE_HI:   res = {1'b1, base[23:16]};
      rscfg_pkg::IDX_BASE_MID:  res = {1'b1, base[15:8]};
      rscfg_pkg::IDX_BASE_LO:   res = {1'b1, base[7:0]};
      rscfg_pkg::IDX_BW_RATE:   res = {1'b1, bwr};
      rscfg_pkg::IDX_RATE_MANT: res = {1'b1, rm};
      default:                  res = 9'h000;
    endcase
    return res;
  endfunction

  // Read decode against current field values
  always_comb begin
    {rd_hit, rd_byte} = read_reg(i_araddr[ADDR_W-1:2], o_if_base_word_a_word,
      if_rsvd, o_synth_offset_word, o_base_word_a,
      {o_bandwidth_exponent, o_bandwidth_mantissa, o_symbol_rate_exponent},
      o_symbol_rate_mantissa);
    wr_hit = (aw_idx >= rscfg_pkg::IDX_IF_CTRL)
          && (aw_idx <= rscfg_pkg::IDX_RATE_MANT);
  end

  // Write address channel; one write in flight at a time
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_awready <= 1'b1;
      aw_held   <= 1'b0;
      aw_idx    <= 16'h0000;
    end else if (i_awvalid && o_awready) begin
      o_awready <= 1'b0;
      aw_held   <= 1'b1;
      aw_idx    <= i_awaddr[ADDR_W-1:2];
    end else if (commit) begin
      aw_held   <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
    end
  end

  // Write data channel, independent of address order
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_wready <= 1'b1;
      w_held   <= 1'b0;
      w_byte   <= 8'h00;
      w_lane   <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      o_wready <= 1'b0;
      w_held   <= 1'b1;
      w_byte   <= i_wdata[7:0];
      w_lane   <= i_wstrb[0];
    end else if (commit) begin
      w_held   <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
    end
  end

  // Write response; unmapped index answers SLVERR
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= rscfg_pkg::RESP_OKAY;
    end else if (commit) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_hit ? rscfg_pkg::RESP_OKAY : rscfg_pkg::RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // IF register: upper two bits not stored so they ignore writes
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_if_base_word_a_word <= rscfg_pkg::RST_IF_WORD;
      if_rsvd        <= rscfg_pkg::RST_IF_RSVD;
    end else if (commit && w_lane && aw_idx == rscfg_pkg::IDX_IF_CTRL) begin
      o_if_base_word_a_word <= w_byte[4:0];
      if_rsvd        <= w_byte[rscfg_pkg::IF_RSVD_BIT];
    end
  end

  // Signed synthesizer offset
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_synth_offset_word <= rscfg_pkg::RST_OFFSET;
    end else if (commit && w_lane
                 && aw_idx == rscfg_pkg::IDX_OFF_CTRL) begin
      o_synth_offset_word <= w_byte;
    end
  end

  // Base word bytes; a write to the high byte drops bits 7:6
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      // Top bits only ever take the reset constant, so they stay 01
      o_base_word_a[23:22]   <= rscfg_pkg::BASE_TOP_BITS;
      o_base_word_a[21:16]   <= rscfg_pkg::RST_BASE_HI;
      o_base_word_a[15:8]    <= rscfg_pkg::RST_BASE_MID;
      o_base_word_a[7:0]     <= rscfg_pkg::RST_BASE_LO;
    end else if (commit && w_lane) begin
      if (aw_idx == rscfg_pkg::IDX_BASE_HI) begin
        o_base_word_a[21:16] <= w_byte[5:0];
      end
      if (aw_idx == rscfg_pkg::IDX_BASE_MID) begin
        o_base_word_a[15:8] <= w_byte;
      end
      if (aw_idx == rscfg_pkg::IDX_BASE_LO) begin
        o_base_word_a[7:0] <= w_byte;
      end
    end
  end

  // Bandwidth and rate exponent register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_bandwidth_exponent   <= rscfg_pkg::RST_BW_EXP;
      o_bandwidth_mantissa   <= rscfg_pkg::RST_BW_MANT;
      o_symbol_rate_exponent <= rscfg_pkg::RST_RATE_EXP;
    end else if (commit && w_lane
                 && aw_idx == rscfg_pkg::IDX_BW_RATE) begin
      o_bandwidth_exponent   <= w_byte[rscfg_pkg::BW_EXP_LSB +: 2];
      o_bandwidth_mantissa   <= w_byte[rscfg_pkg::BW_MANT_LSB +: 2];
      o_symbol_rate_exponent <= w_byte[3:0];
    end
  end

  // Rate mantissa byte
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_symbol_rate_mantissa <= rscfg_pkg::RST_RATE_MANT;
    end else if (commit && w_lane
                 && aw_idx == rscfg_pkg::IDX_RATE_MANT) begin
      o_symbol_rate_mantissa <= w_byte;
    end
  end

  // Read channel; data registered at address acceptance
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= rscfg_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= {24'h00_0000, rd_byte};
      o_rresp   <= rd_hit ? rscfg_pkg::RESP_OKAY : rscfg_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
    end
  end

  // Frequency word seen by the synthesizer
  rscfg_synth_word u_synth (
    .i_ref_clk       (i_ref_clk),
    .i_nrst          (i_nrst),
    .i_base_word     (o_base_word_a),
    .i_offset_word   (o_synth_offset_word),
    .i_if_word       (o_if_base_word_a_word),
    .i_channel_index (i_channel_index),
    .i_channel_index_spacing  (i_channel_index_spacing),
    .i_rx_active     (i_rx_active),
    .o_synth_word    (o_synth_word)
  );

  // Filter and symbol timing derivations
  rscfg_rate_calc u_rate (
    .i_ref_clk     (i_ref_clk),
    .i_nrst        (i_nrst),
    .i_bw_exp      (o_bandwidth_exponent),
    .i_bw_mant     (o_bandwidth_mantissa),
    .i_rate_exp    (o_symbol_rate_exponent),
    .i_rate_mant   (o_symbol_rate_mantissa),
    .o_decim_ratio (o_decim_ratio),
    .o_rate_word   (o_rate_word)
  );

  // Steps of a write to a given index
  sequence s_write_to(logic [15:0] idx);
    commit && w_lane && aw_idx == idx;
  endsequence

  a_if_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_write_to(rscfg_pkg::IDX_IF_CTRL) |=>
    o_if_base_word_a_word == $past(w_byte[4:0]))
    else $error("IF field not written");
  a_if_unused_zero: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    i_arvalid && o_arready && i_araddr[ADDR_W-1:2] == rscfg_pkg::IDX_IF_CTRL
    |=> o_rdata[7:6] == 2'b00 && o_rdata[5] == $past(if_rsvd))
    else $error("IF unused bits not zero");
  a_base_top_fixed: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    s_write_to(rscfg_pkg::IDX_BASE_HI) |=>
    o_base_word_a[23:22] == 2'b01
    && o_base_word_a[21:16] == $past(w_byte[5:0]))
    else $error("Base high byte wrong");
  a_offset_write: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    s_write_to(rscfg_pkg::IDX_OFF_CTRL) |=> ##1
    o_synth_offset_word == $past(w_byte, 2))
    else $error("Offset not written");
  a_rate_exp_write: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    s_write_to(rscfg_pkg::IDX_BW_RATE) |=>
    o_symbol_rate_exponent == $past(w_byte[3:0])
    && o_bandwidth_exponent == $past(w_byte[7:6]))
    else $error("Exponent register not written");
  a_mant_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !(commit && aw_idx == rscfg_pkg::IDX_RATE_MANT) |=>
    $stable(o_symbol_rate_mantissa))
    else $error("Mantissa changed without write");
  a_channel_index_add: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !i_rx_active && o_synth_offset_word == 8'h00 |=> o_synth_word ==
    24'($past(o_base_word_a)
    + $past(i_channel_index) * $past(i_channel_index_spacing)))
    else $error("Channel term not added");
  a_bvalid_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("Write response dropped");

  // Read answer must stand until the master takes it
  a_rvalid_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
    && $stable(o_rresp))
    else $error("Read answer dropped");

  // Unmapped writes must be refused with an error response
  a_wr_refused: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    commit && !wr_hit |=> o_bresp == rscfg_pkg::RESP_SLVERR)
    else $error("Unmapped write not refused");

  // Masked low lane leaves the IF, reserved, offset and base word fields alone
  a_masked_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    commit && !w_lane |=> $stable(o_if_base_word_a_word) && $stable(if_rsvd)
    && $stable(o_synth_offset_word) && $stable(o_base_word_a))
    else $error("Masked write changed a field");

  // Remaining fields follow their writes
  a_mant_write: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    s_write_to(rscfg_pkg::IDX_RATE_MANT) |=>
    o_symbol_rate_mantissa == $past(w_byte))
    else $error("Mantissa not written");
  a_bw_mant_write: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    s_write_to(rscfg_pkg::IDX_BW_RATE) |=>
    o_bandwidth_mantissa == $past(w_byte[5:4]))
    else $error("Bandwidth mantissa not written");
endmodule // rscfg_regs
`default_nettype wire

//--- tb/rscfg_tb.sv
// Self-checking bench for the synthesizer and modem rate config bank
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;          // 200 MHz reference clock
  logic        nrst;         // Sync reset, active low
  logic [17:0] awaddr;       // Write byte address
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [17:0] araddr;       // Read byte address
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [7:0]  channel_index;         // Channel index feed
  logic [15:0] spacing;      // Channel spacing feed
  logic        rx;           // Receive phase flag
  logic [4:0]  ifw_o;
  logic [7:0]  off_o;
  logic [23:0] base_o;
  logic [1:0]  bwe_o;
  logic [1:0]  bwm_o;
  logic [3:0]  re_o;
  logic [7:0]  rm_o;
  logic [23:0] synth_o;
  logic [8:0]  decim_o;
  logic [23:0] rate_o;
  int          mismatches;   // Failed compares
  int          checks;       // All compares
  int          seed = 32'h1230ff12;
  logic [1:0]  bq[$];        // Expected write responses, oldest first
  logic [33:0] rq[$];        // Expected {resp, data} of reads
  logic [1:0]  b_exp;        // Note taken off the write queue
  logic [33:0] r_exp;        // Note taken off the read queue

  rscfg_regs #(.ADDR_W(18)) dut (
    .i_ref_clk(clk), .i_nrst(nrst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_channel_index(channel_index),
    .i_channel_index_spacing(spacing), .i_rx_active(rx),
    .o_if_base_word_a_word(ifw_o), .o_synth_offset_word(off_o),
    .o_base_word_a(base_o), .o_bandwidth_exponent(bwe_o),
    .o_bandwidth_mantissa(bwm_o), .o_symbol_rate_exponent(re_o),
    .o_symbol_rate_mantissa(rm_o), .o_synth_word(synth_o),
    .o_decim_ratio(decim_o), .o_rate_word(rate_o)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Okay read answer carrying one byte in lane 0
  function automatic logic [33:0] ok(input logic [7:0] d);
    return {rscfg_pkg::RESP_OKAY, 24'h00_0000, d};
  endfunction

  // Write one register; address and data offered together
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [3:0] st, input logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(resp);
    awaddr  <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= {24'h00_0000, d};
    wstrb   <= st;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // Read one register; the answer is judged by the monitor
  task automatic rd(input logic [15:0] idx, input logic [33:0] e);
    rq.push_back(e);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Monitor: each bus answer is matched to the oldest note
  // Pop once into a holder: the macro reads its expected value twice
  always @(posedge clk) begin
    if (bvalid && bready) begin
      b_exp = bq.pop_front();
      `CHK(bresp, b_exp)
    end
    if (rvalid && rready) begin
      r_exp = rq.pop_front();
      `CHK({rresp, rdata}, r_exp)
    end
  end

  // Single place where the run ends
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [7:0]  ifb;
    logic [7:0]  off;
    logic [7:0]  hi;
    logic [7:0]  mid;
    logic [7:0]  lo;
    logic [7:0]  rm;
    logic [3:0]  k;
    logic [23:0] base;
    logic [23:0] exp_w;
    mismatches = 0;
    checks = 0;
    nrst = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, channel_index, spacing, rx} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset image of every register
    rd(rscfg_pkg::IDX_IF_CTRL, ok(8'h0f));
    rd(rscfg_pkg::IDX_OFF_CTRL, ok(8'h00));
    rd(rscfg_pkg::IDX_BASE_HI, ok(8'h5e));
    rd(rscfg_pkg::IDX_BASE_MID, ok(8'hc4));
    rd(rscfg_pkg::IDX_BASE_LO, ok(8'hec));
    rd(rscfg_pkg::IDX_BW_RATE, ok(8'h8c));
    rd(rscfg_pkg::IDX_RATE_MANT, ok(8'h22));
    `CHK(base_o, 24'h5e_c4ec)
    `CHK(decim_o, 9'h080)
    `CHK(rate_o, 24'h12_2000)
    // Masked lane and unmapped places leave the image alone
    wr(rscfg_pkg::IDX_IF_CTRL, 8'h01, 4'h0, rscfg_pkg::RESP_OKAY);
    rd(rscfg_pkg::IDX_IF_CTRL, ok(8'h0f));
    wr(16'hdf0e, 8'h55, 4'hf, rscfg_pkg::RESP_SLVERR);
    rd(16'hdf0e, {rscfg_pkg::RESP_SLVERR, 32'h0000_0000});
    rd(16'hdf06, {rscfg_pkg::RESP_SLVERR, 32'h0000_0000});
    // Random tuning; receive flag alternates to cover both paths
    for (int i = 0; i < 8; i++) begin
      ifb = 8'($random(seed));
      off = 8'($random(seed));
      hi = 8'($random(seed));
      mid = 8'($random(seed));
      lo = 8'($random(seed));
      channel_index <= 8'($random(seed));
      spacing <= 16'($random(seed));
      rx <= i[0];
      wr(rscfg_pkg::IDX_IF_CTRL, ifb, 4'hf, rscfg_pkg::RESP_OKAY);
      wr(rscfg_pkg::IDX_OFF_CTRL, off, 4'h1, rscfg_pkg::RESP_OKAY);
      wr(rscfg_pkg::IDX_BASE_HI, hi, 4'hf, rscfg_pkg::RESP_OKAY);
      wr(rscfg_pkg::IDX_BASE_MID, mid, 4'h1, rscfg_pkg::RESP_OKAY);
      wr(rscfg_pkg::IDX_BASE_LO, lo, 4'hf, rscfg_pkg::RESP_OKAY);
      rd(rscfg_pkg::IDX_IF_CTRL, ok({2'b00, ifb[5:0]}));
      rd(rscfg_pkg::IDX_BASE_HI, ok({2'b01, hi[5:0]}));
      base = {2'b01, hi[5:0], mid, lo};
      exp_w = base + 24'(channel_index) * 24'(spacing) + {{14{off[7]}}, off, 2'b00}
              - (rx ? {13'h0000, ifb[4:0], 6'h00} : 24'h00_0000);
      `CHK(synth_o, exp_w)
      `CHK(ifw_o, ifb[4:0])
      `CHK(off_o, off)
      `CHK(base_o, base)
    end
    // Every exponent and bandwidth code with a random mantissa
    for (int e = 0; e < 16; e++) begin
      k = 4'(e);
      rm = 8'($random(seed));
      wr(rscfg_pkg::IDX_BW_RATE, {k[1:0], k[3:2], k}, 4'hf,
         rscfg_pkg::RESP_OKAY);
      wr(rscfg_pkg::IDX_RATE_MANT, rm, 4'hf, rscfg_pkg::RESP_OKAY);
      rd(rscfg_pkg::IDX_BW_RATE, ok({k[1:0], k[3:2], k}));
      rd(rscfg_pkg::IDX_RATE_MANT, ok(rm));
      `CHK(bwe_o, k[1:0])
      `CHK(bwm_o, k[3:2])
      `CHK(re_o, k)
      `CHK(rm_o, rm)
      `CHK(decim_o, 9'((8 * (4 + k[3:2])) << k[1:0]))
      `CHK(rate_o, 24'((256 + rm) << k))
    end
    // Mid-run reset must restore the bandwidth/rate and rate mantissa registers written over above
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(rscfg_pkg::IDX_BW_RATE, ok(8'h8c));
    rd(rscfg_pkg::IDX_RATE_MANT, ok(8'h22));
    `CHK(rate_o, 24'h12_2000)
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
